// ---- test/dpp_host.sv ----
// host adapter model that drives the shared two-wire link and the reset line
`timescale 1ns/1ns
module dpp_host (
	input  wire logic clk_sys,  // bench clock that times the link
	input  wire logic wire_lvl, // resolved data line level
	output logic      lnk_clk,  // serial clock towards the device
	output logic      lnk_d,    // data value while driving
	output logic      lnk_oe,   // data drive enable
	output logic      rst_pin   // device reset line, high halts
);
	localparam int HALF = 8; // 80 ns half period of the 160 ns link clock
	initial begin
		lnk_clk = 1'b1;
		lnk_d   = 1'b1;
		lnk_oe  = 1'b1;
		rst_pin = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// ****
	// reset line and frame transfer
	// ****
	task automatic halt(input logic v);
		rst_pin <= v;
		wt(4);
	endtask
	task automatic send(input logic [31:0] f, output logic ack);
		lnk_d <= 1'b0;
		wt(HALF);
		for (int i = 31; i >= 0; i--) begin
			lnk_clk <= 1'b0;
			wt(HALF / 2);
			lnk_d <= f[i];
			wt(HALF / 2);
			lnk_clk <= 1'b1;
			wt(HALF);
		end
		// clock stands high so a slow flash job can finish before the ack fall
		wt(5 * HALF);
		lnk_clk <= 1'b0;
		lnk_oe  <= 1'b0;
		wt(HALF);
		lnk_clk <= 1'b1;
		wt(HALF / 2);
		@(negedge clk_sys);
		ack = wire_lvl;
		wt(HALF / 2);
		lnk_clk <= 1'b0;
		wt(HALF);
		lnk_d  <= 1'b1;
		lnk_oe <= 1'b1;
		wt(2);
		lnk_clk <= 1'b1;
		wt(HALF);
	endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the shared programming and debug port
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	typedef struct packed {
		logic [31:0] frame; // frame sent by the host
		logic        halt;  // reset line held during the frame
		logic        ack;   // expected answer bit
		logic        fl;    // flash job expected
		logic [1:0]  op;    // expected flash operation
		logic        hq;    // expected cpu halt afterwards
	} dpp_row_t;
	logic        clk_sys, nrst, lnk_clk, lnk_d, lnk_oe, rst_pin, wire_q, ack;
	logic        pad_clk_out, pad_clk_oe, pad_data_out, pad_data_oe;
	logic        gpio_clk_out, gpio_clk_oe, gpio_data_out, gpio_data_oe;
	logic        clk_en, pins_en_wr, pins_en_wdata, debug_pins_enable, cpu_pc_valid;
	logic        cpu_halt, cpu_step, cpu_reset_req, bp_hit, flash_req, flash_done;
	logic [1:0]  flash_op, fl_op;
	logic [15:0] cpu_pc, flash_addr;
	logic [7:0]  flash_wdata;
	logic [23:0] fl_ad;
	int          fails, compares, n_step, n_rst, n_bp, n_fl, fl_cnt, fl_dly, nb;
	dpp_row_t    rows [10];
	dpp_row_t    r;
	// undriven data line shows a changing pattern, never a held value
	wire wire_lvl = pad_data_oe ? pad_data_out : (lnk_oe ? lnk_d : ~wire_q);
	wire clk_lvl  = pad_clk_oe ? pad_clk_out : lnk_clk;
	dpp_port dpp_port_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
		.pad_clk_in(clk_lvl), .pad_data_in(wire_lvl), .pad_clk_out(pad_clk_out),
		.pad_clk_oe(pad_clk_oe), .pad_data_out(pad_data_out), .pad_data_oe(pad_data_oe),
		.rst_pin(rst_pin), .gpio_clk_out(gpio_clk_out), .gpio_clk_oe(gpio_clk_oe),
		.gpio_data_out(gpio_data_out), .gpio_data_oe(gpio_data_oe), .pins_en_wr(pins_en_wr),
		.pins_en_wdata(pins_en_wdata), .debug_pins_enable(debug_pins_enable),
		.cpu_pc(cpu_pc), .cpu_pc_valid(cpu_pc_valid), .cpu_halt(cpu_halt),
		.cpu_step(cpu_step), .cpu_reset_req(cpu_reset_req), .bp_hit(bp_hit),
		.flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata), .flash_done(flash_done));
	dpp_host dpp_host_inst (.clk_sys(clk_sys), .wire_lvl(wire_lvl), .lnk_clk(lnk_clk),
		.lnk_d(lnk_d), .lnk_oe(lnk_oe), .rst_pin(rst_pin));
	// ****
	// flash controller stand-in and pulse counters
	// ****
	always @(posedge clk_sys) begin
		wire_q <= wire_lvl;
		n_step <= n_step + int'(cpu_step === 1'b1);
		n_rst <= n_rst + int'(cpu_reset_req === 1'b1);
		n_bp <= n_bp + int'(bp_hit === 1'b1);
		fl_cnt <= (flash_req === 1'b1) ? fl_cnt + 1 : 0;
		flash_done <= (flash_req === 1'b1) && fl_cnt >= fl_dly;
		if (flash_req === 1'b1 && fl_cnt == 0) begin
			n_fl <= n_fl + 1;
			fl_op <= flash_op;
			fl_ad <= {flash_addr, flash_wdata};
		end
	end
	task automatic wrap_up;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic pc_hit(input logic [15:0] a);
		cpu_pc <= a;
		cpu_pc_valid <= 1'b1;
		@(posedge clk_sys);
		cpu_pc_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic frm(input logic [7:0] c, input logic [23:0] ad);
		dpp_host_inst.send({c, ad}, ack);
		repeat (4) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		fails++;
		$display("watchdog expired");
		wrap_up();
	end
	// ****
	// main sequence
	// ****
	initial begin
		{nrst, gpio_clk_out, gpio_clk_oe, gpio_data_out, gpio_data_oe} = 5'h00;
		{pins_en_wr, pins_en_wdata, cpu_pc_valid, flash_done, wire_q} = 5'h00;
		clk_en = 1'b1;
		{cpu_pc, fl_op, fl_ad} = '0;
		{fails, compares, n_step, n_rst, n_bp, n_fl, fl_cnt, fl_dly} = '0;
		rows = '{
			'{{dpp_pkg::CMD_RESET, 24'h000000}, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0},
			'{{dpp_pkg::CMD_ERASE, 24'h000000}, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0},
			'{{dpp_pkg::CMD_STOP, 24'h000000}, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1},
			'{{dpp_pkg::CMD_STEP, 24'h000000}, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1},
			'{{dpp_pkg::CMD_PROG, 24'h1234A5}, 1'b0, 1'b0, 1'b1, dpp_pkg::FOP_PROG, 1'b1},
			'{{dpp_pkg::CMD_OPTION, 24'h00035A}, 1'b0, 1'b0, 1'b1, dpp_pkg::FOP_OPTION, 1'b1},
			'{{dpp_pkg::CMD_RUN, 24'h000000}, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1},
			'{{dpp_pkg::CMD_ERASE, 24'h000000}, 1'b1, 1'b0, 1'b1, dpp_pkg::FOP_ERASE, 1'b1},
			'{{8'h7F, 24'h000000}, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0},
			'{{dpp_pkg::CMD_RUN_TO, 24'h020000}, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0}};
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK("enable after reset", 1'b1, debug_pins_enable)
		`CHK("pad enables", 2'b00, {pad_clk_oe, pad_data_oe})
		`CHK("reset halt flash", 2'b00, {cpu_halt, flash_req})
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			r = rows[i];
			fl_dly = (i % 2 == 1) ? 20 : 0;
			dpp_host_inst.halt(r.halt);
			nb = n_fl;
			frm(r.frame[31:24], r.frame[23:0]);
			`CHK("ack", r.ack, ack)
			`CHK("flash jobs", int'(r.fl), n_fl - nb)
			if (r.fl) `CHK("flash op", r.op, fl_op)
			if (r.fl && r.op != dpp_pkg::FOP_ERASE) `CHK("flash fields", r.frame[23:0], fl_ad)
			`CHK("cpu halt", r.hq, cpu_halt)
			$display("row %0d done", i);
		end
		`CHK("step pulses", 1, n_step)
		`CHK("reset pulses", 1, n_rst)
		pc_hit(16'h01FF);
		`CHK("early halt", 1'b0, cpu_halt)
		pc_hit(16'h0200);
		`CHK("run to halt", 1'b1, cpu_halt)
		$display("run to cursor test done");
		for (int i = 0; i < 4; i++) frm(dpp_pkg::CMD_SET_BP, {16'h0100 + 16'(i * 16), 8'h80 | 8'(i)});
		nb = n_bp;
		for (int i = 0; i < 4; i++) begin
			frm(dpp_pkg::CMD_RUN, 24'h000000);
			pc_hit(16'h0100 + 16'(i * 16));
			`CHK("bp halt", 1'b1, cpu_halt)
		end
		`CHK("bp pulses", 4, n_bp - nb)
		frm(dpp_pkg::CMD_SET_BP, 24'h012002);
		frm(dpp_pkg::CMD_RUN, 24'h000000);
		pc_hit(16'h0120);
		`CHK("disarmed bp", 1'b0, cpu_halt)
		$display("breakpoint test done");
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		pins_en_wr <= 1'b1;
		pins_en_wdata <= 1'b0;
		@(posedge clk_sys);
		{clk_en, pins_en_wr} <= 2'h2;
		repeat (2) @(posedge clk_sys);
		`CHK("frozen enable", 1'b1, debug_pins_enable)
		pins_en_wr <= 1'b1;
		pins_en_wdata <= 1'b0;
		@(posedge clk_sys);
		pins_en_wr <= 1'b0;
		{gpio_clk_out, gpio_clk_oe, gpio_data_out, gpio_data_oe} <= 4'b1010;
		repeat (3) @(posedge clk_sys);
		`CHK("enable cleared", 1'b0, debug_pins_enable)
		`CHK("gpio pins", 4'b1010, {pad_clk_out, pad_clk_oe, pad_data_out, pad_data_oe})
		frm(dpp_pkg::CMD_STOP, 24'h000000);
		`CHK("ignored frame", 1'b0, cpu_halt)
		dpp_host_inst.halt(1'b1);
		nb = n_fl;
		frm(dpp_pkg::CMD_ERASE, 24'h000000);
		`CHK("recovery erase", {1'b0, 32'h1, dpp_pkg::FOP_ERASE}, {ack, n_fl - nb, fl_op})
		// port logic now drives both enables so the regain must visibly drop them
		{gpio_clk_out, gpio_clk_oe, gpio_data_out, gpio_data_oe} <= 4'h5;
		dpp_host_inst.halt(1'b0);
		repeat (2) @(posedge clk_sys);
		`CHK("gpio enables", 4'h5, {pad_clk_out, pad_clk_oe, pad_data_out, pad_data_oe})
		pins_en_wr <= 1'b1;
		pins_en_wdata <= 1'b1;
		@(posedge clk_sys);
		pins_en_wr <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK("enable set", 3'b100, {debug_pins_enable, pad_clk_oe, pad_data_oe})
		frm(dpp_pkg::CMD_STOP, 24'h000000);
		`CHK("stop after regain", 1'b1, cpu_halt)
		$display("pin sharing test done");
		{pins_en_wr, pins_en_wdata} <= 2'h2;
		@(posedge clk_sys);
		pins_en_wr <= 1'b0;
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK("second reset", 3'h4, {debug_pins_enable, cpu_halt, flash_req})
		$display("second reset test done");
		wrap_up();
	end
endmodule

// ---- verilog/dpp_pkg.sv ----
// constants shared by the debug and programming port
package dpp_pkg;
	localparam int unsigned FRAME_BITS   = 32;
	localparam int unsigned CNT_W        = 6;
	localparam int unsigned ADDR_W       = 16;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned BP_COUNT     = 4;
	localparam int unsigned BP_IDX_W     = 2;
	// frame layout, first bit on the wire is the top bit
	localparam int unsigned CMD_MSB      = 31;
	localparam int unsigned CMD_LSB      = 24;
	localparam int unsigned ADDR_MSB     = 23;
	localparam int unsigned ADDR_LSB     = 8;
	localparam int unsigned DATA_MSB     = 7;
	localparam int unsigned DATA_LSB     = 0;
	localparam int unsigned BP_ARM_BIT   = 7;
	localparam logic [CNT_W-1:0] LAST_BIT = 6'h1F;
	localparam logic        PINS_ENABLE_RESET = 1'b1;
	// command codes
	localparam logic [7:0] CMD_RESET     = 8'h01;
	localparam logic [7:0] CMD_RUN       = 8'h02;
	localparam logic [7:0] CMD_STOP      = 8'h03;
	localparam logic [7:0] CMD_STEP      = 8'h04;
	localparam logic [7:0] CMD_RUN_TO    = 8'h05;
	localparam logic [7:0] CMD_SET_BP    = 8'h06;
	localparam logic [7:0] CMD_ERASE     = 8'h10;
	localparam logic [7:0] CMD_PROG      = 8'h11;
	localparam logic [7:0] CMD_OPTION    = 8'h12;
	// flash operation codes towards the flash controller
	localparam logic [1:0] FOP_ERASE     = 2'h0;
	localparam logic [1:0] FOP_PROG      = 2'h1;
	localparam logic [1:0] FOP_OPTION    = 2'h2;
	typedef enum logic [2:0] {
		DPP_IDLE  = 3'b000,
		DPP_SHIFT = 3'b001,
		DPP_EXEC  = 3'b010,
		DPP_FLASH = 3'b011,
		DPP_AWAIT = 3'b100,
		DPP_ACK   = 3'b101
	} dpp_state_t;
endpackage

// ---- verilog/dpp_port.sv ----
// shared two-wire programming and debug port with breakpoint unit
`timescale 1ns/1ns
module dpp_port (
	input  wire logic                        clk_sys,        // system clock, 100 MHz
	input  wire logic                        nrst,           // synchronous reset, active low
	input  wire logic                        clk_en,         // clock enable, freezes state
	input  wire logic                        pad_clk_in,     // shared clock pin level
	input  wire logic                        pad_data_in,    // shared data pin level
	output logic                             pad_clk_out,    // clock pin output value
	output logic                             pad_clk_oe,     // clock pin output enable
	output logic                             pad_data_out,   // data pin output value
	output logic                             pad_data_oe,    // data pin output enable
	input  wire logic                        rst_pin,        // device reset line, high halts
	input  wire logic                        gpio_clk_out,   // port logic value for clock pin
	input  wire logic                        gpio_clk_oe,    // port logic enable for clock pin
	input  wire logic                        gpio_data_out,  // port logic value for data pin
	input  wire logic                        gpio_data_oe,   // port logic enable for data pin
	input  wire logic                        pins_en_wr,     // cpu write strobe of enable bit
	input  wire logic                        pins_en_wdata,  // value written to enable bit
	output logic                             debug_pins_enable, // enable bit state
	input  wire logic [dpp_pkg::ADDR_W-1:0]  cpu_pc,         // cpu fetch address
	input  wire logic                        cpu_pc_valid,   // cpu fetch strobe
	output logic                             cpu_halt,       // stall cpu and peripherals
	output logic                             cpu_step,       // one instruction pulse
	output logic                             cpu_reset_req,  // cpu reset pulse
	output logic                             bp_hit,         // breakpoint hit pulse
	output logic                             flash_req,      // flash operation request level
	output logic [1:0]                       flash_op,       // flash operation code
	output logic [dpp_pkg::ADDR_W-1:0]       flash_addr,     // flash or option address
	output logic [dpp_pkg::DATA_W-1:0]       flash_wdata,    // flash write data
	input  wire logic                        flash_done      // flash operation finished
);
	logic                            s_clk;
	logic                            s_dat;
	logic                            s_rst;
	logic                            s_clk_d;
	logic                            s_dat_d;
	logic                            rise;
	logic                            fall;
	logic                            start;
	logic                            own;
	logic                            dbg_stop;
	logic                            ack_ok;
	logic [dpp_pkg::CNT_W-1:0]       bit_cnt;
	logic [dpp_pkg::FRAME_BITS-1:0]  frame;
	logic [7:0]                      cmd;
	logic                            is_flash;
	logic [dpp_pkg::BP_COUNT-1:0]    bp_arm;
	logic [dpp_pkg::BP_COUNT-1:0]    bp_match;
	logic [dpp_pkg::ADDR_W-1:0]      bp_addr [dpp_pkg::BP_COUNT];
	logic [dpp_pkg::ADDR_W-1:0]      cursor_addr;
	logic                            cursor_arm;
	logic                            cursor_match;
	logic                            match_any;
	logic [dpp_pkg::BP_IDX_W-1:0]    bp_idx;
	dpp_pkg::dpp_state_t             state;

	// ************************************************************
	// pin sampling
	// ************************************************************
	dpp_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clk_en  (clk_en),
		.d       ({pad_clk_in, pad_data_in, rst_pin}),
		.q       ({s_clk, s_dat, s_rst})
	);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_clk_d <= 1'b0;
			s_dat_d <= 1'b1;
		end else if (clk_en) begin
			s_clk_d <= s_clk;
			s_dat_d <= s_dat;
		end
	end

	// a frame opens with data falling while the clock is high
	assign rise  = s_clk & ~s_clk_d;
	assign fall  = ~s_clk & s_clk_d;
	assign start = s_clk & s_clk_d & s_dat_d & ~s_dat;
	// a held reset line hands the pins over regardless of the enable bit
	assign own   = debug_pins_enable | s_rst;
	assign cmd   = frame[dpp_pkg::CMD_MSB:dpp_pkg::CMD_LSB];
	assign bp_idx = frame[dpp_pkg::BP_IDX_W-1:0];
	assign is_flash = (cmd == dpp_pkg::CMD_ERASE) || (cmd == dpp_pkg::CMD_PROG)
		|| (cmd == dpp_pkg::CMD_OPTION);

	// ************************************************************
	// pin enable bit
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			debug_pins_enable <= dpp_pkg::PINS_ENABLE_RESET;
		end else if (clk_en && pins_en_wr) begin
			debug_pins_enable <= pins_en_wdata;
		end
	end

	// ************************************************************
	// pad drive
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pad_clk_out  <= 1'b0;
			pad_clk_oe   <= 1'b0;
			pad_data_out <= 1'b0;
			pad_data_oe  <= 1'b0;
		end else if (clk_en) begin
			if (own) begin
				pad_clk_out  <= 1'b0;
				pad_clk_oe   <= 1'b0;
				pad_data_out <= ~ack_ok;
				pad_data_oe  <= (state == dpp_pkg::DPP_ACK);
			end else begin
				pad_clk_out  <= gpio_clk_out;
				pad_clk_oe   <= gpio_clk_oe;
				pad_data_out <= gpio_data_out;
				pad_data_oe  <= gpio_data_oe;
			end
		end
	end

	// ************************************************************
	// frame receiver and command sequencer
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state   <= dpp_pkg::DPP_IDLE;
			bit_cnt <= '0;
			frame   <= '0;
			ack_ok  <= 1'b0;
		end else if (clk_en) begin
			case (state)
				dpp_pkg::DPP_IDLE: begin
					if (own && start) begin
						state   <= dpp_pkg::DPP_SHIFT;
						bit_cnt <= '0;
					end
				end
				dpp_pkg::DPP_SHIFT: begin
					if (!own) begin
						state <= dpp_pkg::DPP_IDLE;
					end else if (start) begin
						bit_cnt <= '0;
					end else if (rise) begin
						frame   <= {frame[dpp_pkg::FRAME_BITS-2:0], s_dat};
						bit_cnt <= bit_cnt + 1'b1;
						if (bit_cnt == dpp_pkg::LAST_BIT) begin
							state <= dpp_pkg::DPP_EXEC;
						end
					end
				end
				dpp_pkg::DPP_EXEC: begin
					// flash work is refused unless the cpu is stalled
					if (is_flash && cpu_halt) begin
						state  <= dpp_pkg::DPP_FLASH;
						ack_ok <= 1'b1;
					end else begin
						state  <= dpp_pkg::DPP_AWAIT;
						ack_ok <= !is_flash;
					end
				end
				dpp_pkg::DPP_FLASH: begin
					if (flash_done) begin
						state <= dpp_pkg::DPP_AWAIT;
					end
				end
				dpp_pkg::DPP_AWAIT: begin
					if (!own) begin
						state <= dpp_pkg::DPP_IDLE;
					end else if (fall) begin
						state <= dpp_pkg::DPP_ACK;
					end
				end
				dpp_pkg::DPP_ACK: begin
					if (!own || fall) begin
						state <= dpp_pkg::DPP_IDLE;
					end
				end
				default: begin
					state <= dpp_pkg::DPP_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// flash request
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flash_req   <= 1'b0;
			flash_op    <= dpp_pkg::FOP_ERASE;
			flash_addr  <= '0;
			flash_wdata <= '0;
		end else if (clk_en) begin
			if (state == dpp_pkg::DPP_EXEC && is_flash && cpu_halt) begin
				flash_req   <= 1'b1;
				flash_addr  <= frame[dpp_pkg::ADDR_MSB:dpp_pkg::ADDR_LSB];
				flash_wdata <= frame[dpp_pkg::DATA_MSB:dpp_pkg::DATA_LSB];
				if (cmd == dpp_pkg::CMD_ERASE) begin
					flash_op <= dpp_pkg::FOP_ERASE;
				end else if (cmd == dpp_pkg::CMD_PROG) begin
					flash_op <= dpp_pkg::FOP_PROG;
				end else begin
					flash_op <= dpp_pkg::FOP_OPTION;
				end
			end else if (flash_done) begin
				flash_req <= 1'b0;
			end
		end
	end

	// ************************************************************
	// breakpoints
	// ************************************************************
	generate
		for (genvar i = 0; i < dpp_pkg::BP_COUNT; i++) begin : g_bp
			assign bp_match[i] = bp_arm[i] && cpu_pc_valid && (cpu_pc == bp_addr[i]);
			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					bp_arm[i]  <= 1'b0;
					bp_addr[i] <= '0;
				end else if (clk_en && state == dpp_pkg::DPP_EXEC
					&& cmd == dpp_pkg::CMD_SET_BP && bp_idx == i) begin
					bp_arm[i]  <= frame[dpp_pkg::BP_ARM_BIT];
					bp_addr[i] <= frame[dpp_pkg::ADDR_MSB:dpp_pkg::ADDR_LSB];
				end
			end
		end
	endgenerate

	assign cursor_match = cursor_arm && cpu_pc_valid && (cpu_pc == cursor_addr);
	assign match_any    = (|bp_match) || cursor_match;

	// ************************************************************
	// execution control
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dbg_stop      <= 1'b0;
			cursor_arm    <= 1'b0;
			cursor_addr   <= '0;
			cpu_step      <= 1'b0;
			cpu_reset_req <= 1'b0;
			bp_hit        <= 1'b0;
			cpu_halt      <= 1'b0;
		end else if (clk_en) begin
			cpu_step      <= 1'b0;
			cpu_reset_req <= 1'b0;
			bp_hit        <= match_any && !dbg_stop;
			if (match_any) begin
				dbg_stop   <= 1'b1;
				cursor_arm <= 1'b0;
			end else if (state == dpp_pkg::DPP_EXEC) begin
				case (cmd)
					dpp_pkg::CMD_RESET: cpu_reset_req <= 1'b1;
					dpp_pkg::CMD_RUN:   dbg_stop <= 1'b0;
					dpp_pkg::CMD_STOP:  dbg_stop <= 1'b1;
					dpp_pkg::CMD_STEP:  cpu_step <= dbg_stop;
					dpp_pkg::CMD_RUN_TO: begin
						cursor_addr <= frame[dpp_pkg::ADDR_MSB:dpp_pkg::ADDR_LSB];
						cursor_arm  <= 1'b1;
						dbg_stop    <= 1'b0;
					end
					default: begin
					end
				endcase
			end
			// a flash job keeps the cpu stalled even if the reset line lets go
			cpu_halt <= dbg_stop || s_rst || (state == dpp_pkg::DPP_FLASH);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	enable_reset_a: assert property ($past(!nrst) |-> debug_pins_enable)
		else $error("enable bit not set after reset");
	pins_clear_a: assert property (clk_en && pins_en_wr && !pins_en_wdata
		|=> !debug_pins_enable)
		else $error("enable bit did not clear");
	pins_set_a: assert property (clk_en && pins_en_wr && pins_en_wdata
		|=> debug_pins_enable)
		else $error("enable bit did not set");
	gpio_pass_a: assert property (clk_en && !own |=>
		pad_data_oe == $past(gpio_data_oe) && pad_clk_oe == $past(gpio_clk_oe))
		else $error("pins not following port logic");
	ignore_link_a: assert property (clk_en && !own && state != dpp_pkg::DPP_EXEC
		&& state != dpp_pkg::DPP_FLASH |=> state == dpp_pkg::DPP_IDLE)
		else $error("link activity seen while pins released");
	flash_halted_a: assert property (flash_req && $past(flash_req) |-> cpu_halt)
		else $error("flash request while cpu running");
	bp_halt_a: assert property (clk_en && match_any ##1 clk_en |=> cpu_halt)
		else $error("breakpoint match did not halt");
	step_halted_a: assert property (cpu_step |-> cpu_halt && dbg_stop)
		else $error("step pulse while running");
	erase_recover_a: assert property (clk_en && s_rst && start
		&& state == dpp_pkg::DPP_IDLE |=> state == dpp_pkg::DPP_SHIFT)
		else $error("held reset line did not open the port");
endmodule

// ---- verilog/dpp_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dpp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_sys, // system clock
	input  wire logic         nrst,    // synchronous reset, active low
	input  wire logic         clk_en,  // clock enable
	input  wire logic [W-1:0] d,       // asynchronous input
	output logic      [W-1:0] q        // synchronised output
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			meta <= '0;
			q    <= '0;
		end else if (clk_en) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
